// file: clk_synth_defs.svh
// register offsets, field masks, preset values and bus constants
// Summary of operation
// - offset 12H holds tuning source 7:6, cap source 5, drive 4:3, zeros 2:0
// - one bit of 12H selects where load capacitance setting comes from
// - offset 13H holds 8-bit load cap code, 0.09375 pF per step
// - reference divider is 42H bits 6:0; ratio is field plus 2
// - 42H bit 7 holds the product counter odd bit
// - 0CH holds bank 1 source select bit 7, divide value 6:0
// - 47H holds bank 2 source select bit 7, divide value 6:0
// - 3-bit output source codes spread over 44H-46H; filler bits are ones
// - 09H enables: output C bit 5, A bit 4, B bit 2; others zero
// - 40H bits 7:5 fixed, 4:2 pump, 1:0 product counter high bits
// - 8-bit register address, 8-bit data, serial slave address 1101001
// - serial writes are volatile; contents return to presets at power-up
`ifndef CLK_SYNTH_DEFS_SVH
`define CLK_SYNTH_DEFS_SVH

// serial slave address
`define DEV_ADDR 7'h69

// register offsets
`define OFS_OUT_EN 8'h09
`define OFS_DIV1 8'h0C
`define OFS_OSC 8'h12
`define OFS_CAP 8'h13
`define OFS_PUMP 8'h40
`define OFS_PROD_LO 8'h41
`define OFS_REFDIV 8'h42
`define OFS_XP0 8'h44
`define OFS_XP1 8'h45
`define OFS_XP2 8'h46
`define OFS_DIV2 8'h47

// writable bit masks
`define MSK_OUT_EN 8'h34
`define MSK_OSC 8'hF8
`define MSK_PUMP 8'h1F
`define MSK_XP0 8'h03
`define MSK_XP1 8'h8F
`define MSK_XP2 8'hC0
`define MSK_FULL 8'hFF

// preset values of fixed bits (also the blank-part reset value)
`define FIX_PUMP 8'hC0
`define FIX_XP0 8'hFC
`define FIX_XP1 8'h70
`define FIX_XP2 8'h3F
`define FIX_NONE 8'h00

// reference divider offset added to the stored field
`define REF_DIV_OFFSET 8'h02

`endif

// file: clk_synth_pkg.sv
// types shared by the configuration register bank
package clk_synth_pkg;

  // serial slave state, gray coded along the write path
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_DEV = 4'h1,
    ST_DEV_ACK = 4'h3,
    ST_PTR = 4'h2,
    ST_PTR_ACK = 4'h6,
    ST_WR = 4'h7,
    ST_WR_ACK = 4'h5,
    ST_RD = 4'h4,
    ST_RD_ACK = 4'hC
  } i2c_state_t;

  // decoded configuration fields driven to the analog core
  typedef struct packed {
    logic output_a_en;
    logic output_b_en;
    logic output_c_en;
    logic bank1_source_sel;
    logic [6:0] bank1_divide_value;
    logic [1:0] tuning_array_addr_source;
    logic load_cap_source_sel;
    logic [1:0] osc_drive_code;
    logic [7:0] load_cap_code;
    logic [2:0] pump_setting;
    logic [9:0] product_counter_base;
    logic product_odd_bit;
    logic [6:0] ref_div_value;
    logic [7:0] ref_div_ratio;
    logic [2:0] output_a_source;
    logic [2:0] output_b_source;
    logic [2:0] output_c_source;
    logic bank2_source_sel;
    logic [6:0] bank2_divide_value;
  } synth_cfg_t;

endpackage

// file: reg_store.sv
// storage of the eleven configuration registers with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "clk_synth_defs.svh"

module reg_store
  import clk_synth_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // access port
  input wire logic wr_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rd_data_o,
  // decoded fields
  output synth_cfg_t cfg_o
);

  localparam int unsigned NREG = 11;

  // offset to storage slot; NREG means unmapped
  function automatic logic [3:0] slot_of(input logic [7:0] a);
    logic [3:0] s;
    s = 4'hB;
    if (a == `OFS_OUT_EN) s = 4'h0;
    else if (a == `OFS_DIV1) s = 4'h1;
    else if (a == `OFS_OSC) s = 4'h2;
    else if (a == `OFS_CAP) s = 4'h3;
    else if (a == `OFS_PUMP) s = 4'h4;
    else if (a == `OFS_PROD_LO) s = 4'h5;
    else if (a == `OFS_REFDIV) s = 4'h6;
    else if (a == `OFS_XP0) s = 4'h7;
    else if (a == `OFS_XP1) s = 4'h8;
    else if (a == `OFS_XP2) s = 4'h9;
    else if (a == `OFS_DIV2) s = 4'hA;
    return s;
  endfunction

  // writable mask and fixed preset per slot
  function automatic logic [15:0] mask_fix(input logic [3:0] s);
    logic [15:0] m;
    m = {`MSK_FULL, `FIX_NONE};
    case (s)
      4'h0: m = {`MSK_OUT_EN, `FIX_NONE};
      4'h2: m = {`MSK_OSC, `FIX_NONE};
      4'h4: m = {`MSK_PUMP, `FIX_PUMP};
      4'h7: m = {`MSK_XP0, `FIX_XP0};
      4'h8: m = {`MSK_XP1, `FIX_XP1};
      4'h9: m = {`MSK_XP2, `FIX_XP2};
      default: m = {`MSK_FULL, `FIX_NONE};
    endcase
    return m;
  endfunction

  // fixed preset of a slot, used as its power-up content
  function automatic logic [7:0] fix_of(input logic [3:0] s);
    logic [15:0] m;
    m = mask_fix(s);
    return m[7:0];
  endfunction

  logic [7:0] mem_reg [NREG];
  logic [7:0] rd_data_reg;
  logic [7:0] ratio_reg;
  wire logic [3:0] slot = slot_of(addr_i);
  wire logic [15:0] mf = mask_fix(slot);
  wire logic hit = (slot != 4'hB);
  wire logic [7:0] wr_val = (wdata_i & mf[15:8]) | mf[7:0];

  // storage; reset stands for the power-up preset state
  always_ff @(posedge sys_clk_i)
  begin
    for (int i = 0; i < NREG; i++)
    begin
      if (!rst_n_i) mem_reg[i] <= fix_of(i[3:0]);
      else if (ce_i && wr_en_i && hit && slot == i[3:0]) mem_reg[i] <= wr_val;
    end
  end

  // registered read data and divide ratio
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      rd_data_reg <= 8'h00;
      ratio_reg <= `REF_DIV_OFFSET;
    end
    else if (ce_i)
    begin
      rd_data_reg <= hit ? mem_reg[slot] : 8'h00;
      if (wr_en_i && addr_i == `OFS_REFDIV) ratio_reg <= {1'b0, wdata_i[6:0]} + `REF_DIV_OFFSET;
    end
  end

  assign rd_data_o = rd_data_reg;

  // field extraction straight from storage flops, except the divide ratio, taken from ratio_reg
  assign cfg_o.output_c_en = mem_reg[0][5];
  assign cfg_o.output_a_en = mem_reg[0][4];
  assign cfg_o.output_b_en = mem_reg[0][2];
  assign cfg_o.bank1_source_sel = mem_reg[1][7];
  assign cfg_o.bank1_divide_value = mem_reg[1][6:0];
  assign cfg_o.tuning_array_addr_source = mem_reg[2][7:6];
  assign cfg_o.load_cap_source_sel = mem_reg[2][5];
  assign cfg_o.osc_drive_code = mem_reg[2][4:3];
  assign cfg_o.load_cap_code = mem_reg[3];
  assign cfg_o.pump_setting = mem_reg[4][4:2];
  assign cfg_o.product_counter_base = {mem_reg[4][1:0], mem_reg[5]};
  assign cfg_o.product_odd_bit = mem_reg[6][7];
  assign cfg_o.ref_div_value = mem_reg[6][6:0];
  assign cfg_o.ref_div_ratio = ratio_reg;
  assign cfg_o.output_b_source = {mem_reg[7][1:0], mem_reg[8][7]};
  assign cfg_o.output_a_source = mem_reg[8][3:1];
  assign cfg_o.output_c_source = {mem_reg[8][0], mem_reg[9][7:6]};
  assign cfg_o.bank2_source_sel = mem_reg[10][7];
  assign cfg_o.bank2_divide_value = mem_reg[10][6:0];

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_pump_fixed_bits: assert property (mem_reg[4][7:5] == 3'b110)
    else $error("fixed bits of pump register changed");
  a_osc_low_zero: assert property (mem_reg[2][2:0] == 3'b000)
    else $error("oscillator register low bits not zero");
  a_cross_filler: assert property (mem_reg[7][7:2] == 6'h3F && mem_reg[9][5:0] == 6'h3F)
    else $error("crosspoint filler bits not ones");
  a_ratio_tracks: assert property (ce_i && wr_en_i && addr_i == `OFS_REFDIV |=>
    ratio_reg == {1'b0, $past(wdata_i[6:0])} + 8'h02)
    else $error("reference ratio not field plus two");
  a_cap_written: assert property (ce_i && wr_en_i && addr_i == `OFS_CAP |=>
    cfg_o.load_cap_code == $past(wdata_i))
    else $error("load cap code not stored");

endmodule
`default_nettype wire

// file: clock_synth_config_registers.sv
// serial slave front end and configuration register bank of the clock synthesizer
`timescale 1ns/1ps
`default_nettype none
`include "clk_synth_defs.svh"

module clock_synth_config_registers
  import clk_synth_pkg::*;
(
  // clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // serial bus pins, open drain data
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // configuration to the synthesizer core
  output synth_cfg_t cfg_o,
  // bus activity
  output logic busy_o
);

  i2c_state_t state_reg, state_next;
  logic scl_q_reg, sda_q_reg;
  logic [7:0] shift_reg, shift_next;
  logic [2:0] bit_cnt_reg, bit_cnt_next;
  logic byte_done_reg, byte_done_next;
  logic [7:0] ptr_reg, ptr_next;
  logic oe_reg, oe_next;
  logic wr_en_reg, wr_en_next;
  logic [7:0] wdata_reg, wdata_next;
  logic nack_reg, nack_next;
  logic busy_reg;
  logic [7:0] rd_data;

  // bus condition detection on registered samples
  wire logic scl_rise = scl_i & ~scl_q_reg;
  wire logic scl_fall = ~scl_i & scl_q_reg;
  wire logic start_cond = scl_i & scl_q_reg & sda_q_reg & ~sda_i;
  wire logic stop_cond = scl_i & scl_q_reg & ~sda_q_reg & sda_i;
  wire logic [7:0] rx_byte = {shift_reg[6:0], sda_i};
  wire logic dev_match = (shift_reg[7:1] == `DEV_ADDR);
  wire logic rx_state = (state_reg == ST_DEV) || (state_reg == ST_PTR) || (state_reg == ST_WR);

  // next-state logic of the serial slave
  always_comb
  begin
    state_next = state_reg;
    shift_next = shift_reg;
    bit_cnt_next = bit_cnt_reg;
    byte_done_next = byte_done_reg;
    ptr_next = ptr_reg;
    oe_next = oe_reg;
    wr_en_next = 1'b0;
    wdata_next = wdata_reg;
    nack_next = nack_reg;
    if (start_cond)
    begin
      state_next = ST_DEV;
      bit_cnt_next = 3'h0;
      byte_done_next = 1'b0;
      oe_next = 1'b0;
    end
    else if (stop_cond)
    begin
      state_next = ST_IDLE;
      oe_next = 1'b0;
    end
    else if (scl_rise)
    begin
      if (rx_state)
      begin
        shift_next = rx_byte;
        bit_cnt_next = bit_cnt_reg + 3'h1;
        byte_done_next = (bit_cnt_reg == 3'h7);
      end
      else if (state_reg == ST_RD_ACK)
        nack_next = sda_i;
    end
    else if (scl_fall)
    begin
      case (state_reg)
        ST_DEV:
          if (byte_done_reg)
          begin
            byte_done_next = 1'b0;
            state_next = dev_match ? ST_DEV_ACK : ST_IDLE;
            oe_next = dev_match;
          end
        ST_PTR:
          if (byte_done_reg)
          begin
            byte_done_next = 1'b0;
            ptr_next = shift_reg;
            state_next = ST_PTR_ACK;
            oe_next = 1'b1;
          end
        ST_WR:
          if (byte_done_reg)
          begin
            byte_done_next = 1'b0;
            wr_en_next = 1'b1;
            wdata_next = shift_reg;
            state_next = ST_WR_ACK;
            oe_next = 1'b1;
          end
        ST_DEV_ACK:
          if (shift_reg[0])
          begin
            state_next = ST_RD;
            shift_next = rd_data;
            oe_next = ~rd_data[7];
            bit_cnt_next = 3'h0;
            ptr_next = ptr_reg + 8'h01;
          end
          else
          begin
            state_next = ST_PTR;
            oe_next = 1'b0;
            bit_cnt_next = 3'h0;
          end
        ST_PTR_ACK, ST_WR_ACK:
        begin
          state_next = ST_WR;
          oe_next = 1'b0;
          bit_cnt_next = 3'h0;
        end
        ST_RD:
          if (bit_cnt_reg == 3'h7)
          begin
            state_next = ST_RD_ACK;
            oe_next = 1'b0;
          end
          else
          begin
            shift_next = {shift_reg[6:0], 1'b0};
            oe_next = ~shift_reg[6];
            bit_cnt_next = bit_cnt_reg + 3'h1;
          end
        ST_RD_ACK:
          if (nack_reg)
            state_next = ST_IDLE;
          else
          begin
            state_next = ST_RD;
            shift_next = rd_data;
            oe_next = ~rd_data[7];
            bit_cnt_next = 3'h0;
            ptr_next = ptr_reg + 8'h01;
          end
        default: oe_next = 1'b0;
      endcase
    end
  end

  // write pointer advances after each stored byte
  wire logic [7:0] ptr_upd = wr_en_reg ? ptr_reg + 8'h01 : ptr_next;

  // slave state registers
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= ST_IDLE;
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
      byte_done_reg <= 1'b0;
      ptr_reg <= 8'h00;
      oe_reg <= 1'b0;
      wr_en_reg <= 1'b0;
      wdata_reg <= 8'h00;
      nack_reg <= 1'b0;
      busy_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      state_reg <= state_next;
      scl_q_reg <= scl_i;
      sda_q_reg <= sda_i;
      shift_reg <= shift_next;
      bit_cnt_reg <= bit_cnt_next;
      byte_done_reg <= byte_done_next;
      ptr_reg <= ptr_upd;
      oe_reg <= oe_next;
      wr_en_reg <= wr_en_next;
      wdata_reg <= wdata_next;
      nack_reg <= nack_next;
      busy_reg <= (state_next != ST_IDLE);
    end
  end

  // register file, addressed by the register pointer
  reg_store u_store (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .wr_en_i(wr_en_reg),
    .addr_i(ptr_reg),
    .wdata_i(wdata_reg),
    .rd_data_o(rd_data),
    .cfg_o(cfg_o)
  );

  assign sda_o = 1'b0; // open drain: only pulls low
  assign sda_oe_o = oe_reg;
  assign busy_o = busy_reg;

  // helper: own-address match captured one cycle earlier
  logic dev_match_q;
  always_ff @(posedge sys_clk_i)
    dev_match_q <= dev_match;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_addr_byte_done;
    ce_i && state_reg == ST_DEV && byte_done_reg && scl_fall && !start_cond && !stop_cond;
  endsequence

  a_ack_own_addr: assert property (s_addr_byte_done |=> (oe_reg == dev_match_q))
    else $error("address acknowledge does not match own address");
  a_ack_after_ptr: assert property (ce_i && state_reg == ST_PTR && byte_done_reg && scl_fall
    && !start_cond && !stop_cond |=> state_reg == ST_PTR_ACK && oe_reg)
    else $error("register address byte not acknowledged");
  a_stop_releases: assert property (ce_i && stop_cond |=> !oe_reg && state_reg == ST_IDLE)
    else $error("bus not released after stop");
  a_write_pulse: assert property (wr_en_reg |=> !wr_en_reg)
    else $error("write strobe longer than one cycle");

endmodule
`default_nettype wire

// file: i2c_host_model.sv
// serial bus master model that drives the register bank's clock and data pins
`timescale 1ns/1ps
`default_nettype none

module i2c_host_model
(
  // clock
  input wire logic sys_clk_i,
  // device pulling the data line low
  input wire logic sda_oe_i,
  // wire levels seen by the device
  output logic scl_o,
  output logic sda_o
);
  logic pull_low = 1'h0;

  // open drain with pull-up, so a released line reads high
  assign sda_o = ~(pull_low | sda_oe_i);

  initial scl_o = 1'h1;

  // one bus phase, more than four clocks between any two pin edges
  task automatic phase();
    repeat (5) @(posedge sys_clk_i);
    #1;
  endtask

  // start or repeated start, data falls while clock is high
  task automatic send_start();
    pull_low = 1'h0;
    phase();
    scl_o = 1'h1;
    phase();
    pull_low = 1'h1;
    phase();
    scl_o = 1'h0;
    phase();
  endtask

  // stop, data rises while clock is high
  task automatic send_stop();
    pull_low = 1'h1;
    phase();
    scl_o = 1'h1;
    phase();
    pull_low = 1'h0;
    phase();
  endtask

  // eight bits msb first then the acknowledge slot; a 1 releases the line
  task automatic xfer(input logic [7:0] tx, input logic ack_tx,
                      output logic [7:0] rx, output logic ack_rx);
    logic [8:0] bits;
    logic [8:0] seen;
    bits = {tx, ack_tx};
    for (int i = 8; i >= 0; i--)
    begin
      pull_low = ~bits[i];
      phase();
      scl_o = 1'h1;
      phase();
      seen[i] = sda_o;
      scl_o = 1'h0;
      phase();
    end
    rx = seen[8:1];
    ack_rx = seen[0];
  endtask
endmodule

`default_nettype wire

// file: testbench.sv
// self-checking bench for the clock synthesizer register bank
`timescale 1ns/1ps
`default_nettype none
`include "clk_synth_defs.svh"

`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin err_count++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, (got), (exp)); end end

module testbench
  import clk_synth_pkg::*;
;
  logic sys_clk = 1'h0;
  logic rst_n;
  logic ce;
  wire logic scl;
  wire logic sda;
  logic sda_oe;
  wire logic sda_drv;
  logic busy;
  synth_cfg_t cfg;
  int err_count = 0;
  int checked = 0;

  localparam logic [7:0] OFS [11] = '{8'h09, 8'h0C, 8'h12, 8'h13, 8'h40, 8'h41,
                                      8'h42, 8'h44, 8'h45, 8'h46, 8'h47};
  localparam logic [7:0] RST [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hC0, 8'h00,
                                      8'h00, 8'hFC, 8'h70, 8'h3F, 8'h00};
  localparam logic [7:0] ONES [11] = '{8'h34, 8'hFF, 8'hF8, 8'hFF, 8'hDF, 8'hFF,
                                       8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  localparam logic [7:0] PAT [11] = '{8'h14, 8'h88, 8'h38, 8'h5A, 8'h0E, 8'h3C,
                                      8'h85, 8'hFE, 8'h87, 8'hBF, 8'h0B};

  // clock
  always #2.5 sys_clk = ~sys_clk;

  clock_synth_config_registers i_dut (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .ce_i(ce), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_drv), .sda_oe_o(sda_oe), .cfg_o(cfg), .busy_o(busy));

  i2c_host_model i_host (.sys_clk_i(sys_clk), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));

  // start, write address and register pointer
  task automatic begin_at(input logic [7:0] ofs);
    logic [7:0] rx;
    logic a0;
    logic a1;
    i_host.send_start();
    i_host.xfer({`DEV_ADDR, 1'h0}, 1'h1, rx, a0);
    i_host.xfer(ofs, 1'h1, rx, a1);
    `CHK({a0, a1}, 2'h0)
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [7:0] val);
    logic [7:0] rx;
    logic a;
    begin_at(ofs);
    i_host.xfer(val, 1'h1, rx, a);
    `CHK(a, 1'h0)
    i_host.send_stop();
  endtask

  // read one register through a repeated start and compare
  task automatic chk_reg(input logic [7:0] ofs, input logic [7:0] exp);
    logic [7:0] rx;
    logic a;
    begin_at(ofs);
    i_host.send_start();
    i_host.xfer({`DEV_ADDR, 1'h1}, 1'h1, rx, a);
    `CHK(a, 1'h0)
    i_host.xfer(8'hFF, 1'h1, rx, a);
    i_host.send_stop();
    `CHK(rx, exp)
    `CHK(busy, 1'h0)
  endtask

  task automatic done(input string name);
    $display("test %s done", name);
  endtask

  task automatic t_reset_values();
    foreach (OFS[i]) chk_reg(OFS[i], RST[i]);
    `CHK(cfg.ref_div_ratio, 8'h02)
    `CHK(sda_drv, 1'h0)
    done("reset_values");
  endtask

  // all ones then all zeros: fixed bits keep their presets
  task automatic t_fixed_bits();
    foreach (OFS[i]) wr(OFS[i], 8'hFF);
    foreach (OFS[i]) chk_reg(OFS[i], ONES[i]);
    `CHK({cfg.output_a_en, cfg.output_b_en, cfg.output_c_en}, 3'h7)
    `CHK(cfg.ref_div_ratio, 8'h81)
    foreach (OFS[i]) wr(OFS[i], 8'h00);
    foreach (OFS[i]) chk_reg(OFS[i], RST[i]);
    done("fixed_bits");
  endtask

  // crystal setup with distinct values in every field
  task automatic t_fields();
    foreach (OFS[i]) wr(OFS[i], PAT[i]);
    `CHK({cfg.output_a_en, cfg.output_b_en, cfg.output_c_en}, 3'h6)
    `CHK({cfg.bank1_source_sel, cfg.bank1_divide_value}, 8'h88)
    `CHK({cfg.tuning_array_addr_source, cfg.load_cap_source_sel, cfg.osc_drive_code}, 5'h07)
    `CHK(cfg.load_cap_code, 8'h5A)
    `CHK({cfg.pump_setting, cfg.product_counter_base}, 13'h0E3C)
    `CHK({cfg.product_odd_bit, cfg.ref_div_value, cfg.ref_div_ratio}, 16'h8507)
    `CHK({cfg.output_a_source, cfg.output_b_source, cfg.output_c_source}, 9'h0EE)
    `CHK({cfg.bank2_source_sel, cfg.bank2_divide_value}, 8'h0B)
    done("fields");
  endtask

  // external clock reference: every drive code, load code left at zero
  task automatic t_drive_codes();
    wr(`OFS_CAP, 8'h00);
    for (int c = 0; c < 4; c++)
    begin
      wr(`OFS_OSC, {3'h0, c[1:0], 3'h0});
      `CHK({cfg.load_cap_source_sel, cfg.osc_drive_code}, {1'h0, c[1:0]})
    end
    done("drive_codes");
  endtask

  // pointer auto-increment across the reserved 43H
  task automatic t_burst();
    logic [7:0] exp [4];
    logic [7:0] rx;
    logic a;
    exp = '{8'hA5, 8'h12, 8'h00, 8'hFD};
    begin_at(`OFS_PROD_LO);
    foreach (exp[i])
    begin
      i_host.xfer(i == 2 ? 8'h77 : (i == 3 ? 8'h01 : exp[i]), 1'h1, rx, a);
    end
    i_host.send_stop();
    `CHK(cfg.ref_div_ratio, 8'h14)
    begin_at(`OFS_PROD_LO);
    i_host.send_start();
    i_host.xfer({`DEV_ADDR, 1'h1}, 1'h1, rx, a);
    foreach (exp[i])
    begin
      i_host.xfer(8'hFF, i == 3, rx, a);
      `CHK(rx, exp[i])
    end
    i_host.send_stop();
    done("burst");
  endtask

  // foreign address is not acknowledged and changes nothing
  task automatic t_refused();
    logic [7:0] rx;
    logic a;
    i_host.send_start();
    i_host.xfer({7'h6A, 1'h0}, 1'h1, rx, a);
    `CHK(a, 1'h1)
    i_host.xfer(`OFS_CAP, 1'h1, rx, a);
    i_host.xfer(8'hEE, 1'h1, rx, a);
    i_host.send_stop();
    chk_reg(`OFS_CAP, 8'h00);
    wr(8'h48, 8'h55);
    chk_reg(8'h48, 8'h00);
    done("refused");
  endtask

  // power loss brings back the presets
  task automatic t_power_cycle();
    synth_cfg_t preset;
    preset = '0;
    preset.ref_div_ratio = 8'h02;
    ce = 1'h0;
    rst_n = 1'h0;
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK(cfg, preset)
    rst_n = 1'h1;
    ce = 1'h1;
    chk_reg(`OFS_PUMP, 8'hC0);
    done("power_cycle");
  endtask

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // main sequence
  initial
  begin
    rst_n = 1'h0;
    ce = 1'h1;
    repeat (3) @(posedge sys_clk);
    #1;
    rst_n = 1'h1;
    t_reset_values();
    t_fixed_bits();
    t_fields();
    t_drive_codes();
    t_burst();
    t_refused();
    t_power_cycle();
    tally_and_finish();
  end

  // watchdog
  initial
  begin
    #400000;
    err_count++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
